// >>> ogfx_effects.sv
`timescale 1ns/10ps
// Function
// - shadow mode fetches the row above along with each 12-bit glyph row.
// - shadow mask tests current bit x against upper-row bit x+1.
// - bit 11 of the current row is never shadowed.
// - shadow mask bits replace the pixel colour with the override colour.
// - border mode fetches rows above and below and examines all eight neighbours.
// - border mask bits replace the pixel colour with the override colour.
// - border output on the glyph perimeter need not be correct.
// - glyph rows are repeated by approximation to keep character height constant.
// - a character is never rendered with fewer than 18 scan rows.
// - codes 0x00 and 0x01 via bank select 0 are terminators, not glyphs.
// - via bank selects 1 to 3 the two lowest codes are ordinary glyphs.
// - the glyph rom is 8 banks with sequential character addresses.
// - the feature select bits of the attribute choose the pixel effect.
module ogfx_effects
   import ogfx_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic cell_req_in,
   input wire logic [7:0] cell_code_in,
   input wire logic [1:0] bank_slot_in,
   input wire logic [2:0] bank_in,
   input wire logic [3:0] feature_select_bits_in,
   input wire logic [8:0] colour0_in,
   input wire logic [8:0] colour1_in,
   input wire logic rom_we_in,
   input wire logic [19:0] rom_waddr_in,
   input wire logic [11:0] rom_wdata_in,
   output logic cell_busy_out,
   output logic pix_valid_out,
   output logic [8:0] pix_colour_out,
   output logic pix_override_out,
   output logic line_end_out,
   output logic screen_end_out
);
   ogfx_rom_if rom_bus();
   ogfx_glyph_rom u_rom (
      .core_clk_in(core_clk_in),
      .we_in(rom_we_in),
      .waddr_in(rom_waddr_in),
      .wdata_in(rom_wdata_in),
      .rom(rom_bus.mem)
   );

   function automatic logic [11:0] shadow_mask(input logic [11:0] up, input logic [11:0] cur);
      shadow_mask = {1'b0, up[11:1] & ~cur[10:0]};
   endfunction

   function automatic logic [11:0] border_mask(input logic [11:0] up, input logic [11:0] cur,
                                               input logic [11:0] dn);
      logic [11:0] nb;
      nb = up | dn | (up << 1) | (up >> 1) | (dn << 1) | (dn >> 1) | (cur << 1) | (cur >> 1);
      border_mask = nb & ~cur;
   endfunction

   // registers
   logic ena_r, ena_nxt;
   logic [8:0] ovr_colour_r, ovr_colour_nxt;
   logic [10:0] lines_r, lines_nxt;
   logic [31:0] wb_dat_nxt;
   logic wb_ack_nxt;
   logic [7:0] rep_r;
   logic [15:0] prod;
   logic wb_hit;

   assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;

   always_comb begin
      ena_nxt = ena_r;
      ovr_colour_nxt = ovr_colour_r;
      lines_nxt = lines_r;
      wb_ack_nxt = wb_hit;
      wb_dat_nxt = BUS_ZERO;
      if (wb_hit) begin
         case (wb_adr_in)
            REG_CTRL: begin
               if (wb_we_in && wb_sel_in[0]) ena_nxt = wb_dat_in[0];
               wb_dat_nxt = {31'h0, ena_r};
            end
            REG_OVR_COLOUR: begin
               if (wb_we_in && wb_sel_in[0]) ovr_colour_nxt[7:0] = wb_dat_in[7:0];
               if (wb_we_in && wb_sel_in[1]) ovr_colour_nxt[8] = wb_dat_in[8];
               wb_dat_nxt = {23'h0, ovr_colour_r};
            end
            REG_LINES: begin
               if (wb_we_in && wb_sel_in[0]) lines_nxt[7:0] = wb_dat_in[7:0];
               if (wb_we_in && wb_sel_in[1]) lines_nxt[10:8] = wb_dat_in[10:8];
               wb_dat_nxt = {21'h0, lines_r};
            end
            REG_STATUS: begin
               wb_dat_nxt = {24'h0, rep_r};
            end
            default: begin
               wb_dat_nxt = BUS_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         ena_r <= 1'b0;
         ovr_colour_r <= OVR_COLOUR_RST;
         lines_r <= LINES_RST;
         wb_ack_out <= 1'b0;
         wb_dat_out <= BUS_ZERO;
      end else begin
         ena_r <= ena_nxt;
         ovr_colour_r <= ovr_colour_nxt;
         lines_r <= lines_nxt;
         wb_ack_out <= wb_ack_nxt;
         wb_dat_out <= wb_dat_nxt;
      end
   end

   // scan lines per glyph row in eighths: 8 * lines / base, floor, never below 8
   assign prod = 16'(lines_r) * 16'h0008;
   logic [7:0] rep_nxt;
   always_comb begin
      rep_nxt = 8'(prod / 16'(BASE_LINES));
      if (rep_nxt < 8'h08) rep_nxt = 8'h08;
   end
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) rep_r <= 8'h08;
      else rep_r <= rep_nxt;
   end

   // cell sequencer
   ogfx_state_e state_r, state_nxt;
   logic [4:0] row_r, row_nxt;
   logic [1:0] ph_r, ph_nxt;
   logic [11:0] up_r, up_nxt, cur_r, cur_nxt, dn_r, dn_nxt;
   logic [11:0] msk_r, msk_nxt;
   logic [3:0] col_r, col_nxt;
   logic [10:0] acc_r, acc_nxt;
   logic [7:0] code_r, code_nxt;
   logic [2:0] bank_r, bank_nxt;
   logic [3:0] feat_r, feat_nxt;
   logic [8:0] c0_r, c0_nxt, c1_r, c1_nxt;
   logic pv_nxt, po_nxt, le_nxt, se_nxt, busy_nxt;
   logic [8:0] pc_nxt;
   logic [4:0] fetch_row;
   logic [11:0] rd;

   assign rom_bus.bank = bank_r;
   assign rom_bus.code = code_r;
   assign rom_bus.row = fetch_row;
   assign rd = rom_bus.data;

   always_comb begin
      case (ph_r)
         2'h0: fetch_row = row_r - 5'h01;
         2'h1: fetch_row = row_r;
         default: fetch_row = row_r + 5'h01;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      row_nxt = row_r;
      ph_nxt = ph_r;
      up_nxt = up_r;
      cur_nxt = cur_r;
      dn_nxt = dn_r;
      msk_nxt = msk_r;
      col_nxt = col_r;
      acc_nxt = acc_r;
      code_nxt = code_r;
      bank_nxt = bank_r;
      feat_nxt = feat_r;
      c0_nxt = c0_r;
      c1_nxt = c1_r;
      pv_nxt = 1'b0;
      po_nxt = 1'b0;
      pc_nxt = pix_colour_out;
      le_nxt = 1'b0;
      se_nxt = 1'b0;
      busy_nxt = 1'b1;
      case (state_r)
         OGFX_IDLE: begin
            busy_nxt = 1'b0;
            if (cell_req_in && ena_r) begin
               if (bank_slot_in == BANK_SEL_TERM && cell_code_in == SCREEN_TERM_CODE) begin
                  se_nxt = 1'b1;
               end else if (bank_slot_in == BANK_SEL_TERM && cell_code_in == LINE_TERM_CODE) begin
                  le_nxt = 1'b1;
               end else begin
                  // other slots display low codes as glyphs
                  code_nxt = cell_code_in;
                  bank_nxt = bank_in;
                  feat_nxt = feature_select_bits_in;
                  c0_nxt = colour0_in;
                  c1_nxt = colour1_in;
                  row_nxt = 5'h00;
                  ph_nxt = 2'h0;
                  acc_nxt = 11'h000;
                  busy_nxt = 1'b1;
                  state_nxt = OGFX_FETCH;
               end
            end
         end
         OGFX_FETCH: begin
            // rom data arrive one cycle late: ph 1..3 capture up, cur, down
            ph_nxt = ph_r + 2'h1;
            case (ph_r)
               2'h1: up_nxt = (row_r == 5'h00) ? 12'h000 : rd;
               2'h2: cur_nxt = rd;
               2'h3: begin
                  dn_nxt = (row_r == 5'(GLYPH_ROWS - 1)) ? 12'h000 : rd;
                  ph_nxt = 2'h0;
                  col_nxt = 4'hB;
                  // credit the row once; the carry below eight rolls into the next row
                  acc_nxt = 11'(acc_r + 11'(rep_r));
                  state_nxt = OGFX_PIX;
               end
               default: begin
               end
            endcase
            if (ph_r == 2'h3) begin
               case (feat_r)
                  FEAT_SHADOW: msk_nxt = shadow_mask(up_r, cur_r);
                  FEAT_BORDER: msk_nxt = border_mask(up_r, cur_r, dn_nxt);
                  default: msk_nxt = 12'h000;
               endcase
            end
         end
         OGFX_PIX: begin
            pv_nxt = 1'b1;
            po_nxt = msk_r[col_r];
            pc_nxt = msk_r[col_r] ? ovr_colour_r : (cur_r[col_r] ? c1_r : c0_r);
            if (col_r == 4'h0) begin
               // approximate repetition: each scan line spends eight eighths of the credit
               acc_nxt = 11'(acc_r - 11'h008);
               if (acc_r >= 11'h010) begin
                  col_nxt = 4'hB;
               end else begin
                  if (row_r == 5'(GLYPH_ROWS - 1)) begin
                     state_nxt = OGFX_DONE;
                  end else begin
                     row_nxt = row_r + 5'h01;
                     state_nxt = OGFX_FETCH;
                  end
               end
            end else begin
               col_nxt = col_r - 4'h1;
            end
         end
         OGFX_DONE: begin
            busy_nxt = 1'b0;
            state_nxt = OGFX_IDLE;
         end
         default: state_nxt = OGFX_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         state_r <= OGFX_IDLE;
         row_r <= 5'h00;
         ph_r <= 2'h0;
         up_r <= 12'h000;
         cur_r <= 12'h000;
         dn_r <= 12'h000;
         msk_r <= 12'h000;
         col_r <= 4'h0;
         acc_r <= 11'h000;
         code_r <= 8'h00;
         bank_r <= 3'h0;
         feat_r <= FEAT_NONE;
         c0_r <= 9'h000;
         c1_r <= 9'h000;
         pix_valid_out <= 1'b0;
         pix_override_out <= 1'b0;
         pix_colour_out <= 9'h000;
         line_end_out <= 1'b0;
         screen_end_out <= 1'b0;
         cell_busy_out <= 1'b0;
      end else begin
         state_r <= state_nxt;
         row_r <= row_nxt;
         ph_r <= ph_nxt;
         up_r <= up_nxt;
         cur_r <= cur_nxt;
         dn_r <= dn_nxt;
         msk_r <= msk_nxt;
         col_r <= col_nxt;
         acc_r <= acc_nxt;
         code_r <= code_nxt;
         bank_r <= bank_nxt;
         feat_r <= feat_nxt;
         c0_r <= c0_nxt;
         c1_r <= c1_nxt;
         pix_valid_out <= pv_nxt;
         pix_override_out <= po_nxt;
         pix_colour_out <= pc_nxt;
         line_end_out <= le_nxt;
         screen_end_out <= se_nxt;
         cell_busy_out <= busy_nxt;
      end
   end

   // helper: scan rows emitted per cell
   logic [9:0] rows_cnt_r;
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || state_r == OGFX_IDLE) rows_cnt_r <= 10'h000;
      else if (state_r == OGFX_PIX && col_r == 4'h0) rows_cnt_r <= rows_cnt_r + 10'h001;
   end

   bit11_clear_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == OGFX_PIX && feat_r == FEAT_SHADOW) |-> !msk_r[11])
      else $error("shadow mask set on bit 11");
   shadow_rel_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == OGFX_PIX && feat_r == FEAT_SHADOW) |-> msk_r[10:0] == (up_r[11:1] & ~cur_r[10:0]))
      else $error("shadow mask mismatch");
   ovr_colour_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == OGFX_PIX && msk_r[col_r]) |=> pix_colour_out == $past(ovr_colour_r))
      else $error("override colour not applied");
   border_self_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == OGFX_PIX && feat_r == FEAT_BORDER) |-> (msk_r & cur_r) == 12'h000)
      else $error("border mask covers glyph pixel");
   min_rows_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == OGFX_DONE) |-> rows_cnt_r >= 10'(GLYPH_ROWS))
      else $error("too few scan rows");
   term_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == OGFX_IDLE && ena_r && cell_req_in && bank_slot_in == BANK_SEL_TERM
       && cell_code_in == SCREEN_TERM_CODE) |=> screen_end_out && state_r == OGFX_IDLE)
      else $error("terminator not decoded");
   low_glyph_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == OGFX_IDLE && ena_r && cell_req_in && bank_slot_in != BANK_SEL_TERM)
      |=> state_r == OGFX_FETCH)
      else $error("glyph not started");
   top_zero_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (state_r == OGFX_FETCH && ph_r == 2'h2 && row_r == 5'h00) |-> up_r == 12'h000)
      else $error("top neighbour not zero");
   wb_ack_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
      else $error("wishbone ack timing");
endmodule

// >>> ogfx_pkg.sv
package ogfx_pkg;
   localparam int GLYPH_W = 12;
   localparam int GLYPH_ROWS = 18;
   localparam int COLOR_W = 9;
   localparam int BANK_W = 3;
   localparam int CODE_W = 8;
   localparam int ROWIDX_W = 5;
   localparam int REP_W = 8;
   localparam int FEAT_W = 4;
   // shadow / border codes inside the feature select bits
   localparam logic [3:0] FEAT_NONE = 4'h0;
   localparam logic [3:0] FEAT_SHADOW = 4'h1;
   localparam logic [3:0] FEAT_BORDER = 4'h2;
   localparam logic [7:0] SCREEN_TERM_CODE = 8'h00;
   localparam logic [7:0] LINE_TERM_CODE = 8'h01;
   localparam logic [1:0] BANK_SEL_TERM = 2'h0;
   // wishbone register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_OVR_COLOUR = 4'h4;
   localparam logic [3:0] REG_LINES = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;
   localparam logic [8:0] OVR_COLOUR_RST = 9'h000;
   localparam logic [10:0] LINES_RST = 11'h000;
   localparam logic [10:0] BASE_LINES = 11'h0F0;
   localparam logic [31:0] BUS_ZERO = 32'h00000000;
   typedef enum logic [3:0] {
      OGFX_IDLE = 4'b0001,
      OGFX_FETCH = 4'b0010,
      OGFX_PIX = 4'b0100,
      OGFX_DONE = 4'b1000
   } ogfx_state_e;
endpackage

// >>> ogfx_rom_if.sv
`timescale 1ns/10ps
interface ogfx_rom_if;
   logic [2:0] bank;
   logic [7:0] code;
   logic [4:0] row;
   logic [11:0] data;
   modport user (output bank, output code, output row, input data);
   modport mem (input bank, input code, input row, output data);
endinterface

// >>> ogfx_glyph_rom.sv
`timescale 1ns/10ps
module ogfx_glyph_rom
   import ogfx_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic we_in,
   input wire logic [19:0] waddr_in,
   input wire logic [11:0] wdata_in,
   ogfx_rom_if.mem rom
);
   // 8 banks of 256 codes, rows laid out sequentially per code
   logic [11:0] mem_r [0:(1<<20)-1];
   logic [11:0] data_r;
   always_ff @(posedge core_clk_in) begin
      if (we_in) begin
         mem_r[waddr_in] <= wdata_in;
      end
      data_r <= mem_r[{1'b0, rom.bank, rom.code, 3'h0, rom.row}];
   end
   assign rom.data = data_r;
endmodule

// >>> ogfx_mixer_model.sv
`timescale 1ns/10ps
module ogfx_mixer_model (
   input wire logic clk_in,
   input wire logic clr_in,
   input wire logic pix_valid_in,
   input wire logic [8:0] pix_colour_in,
   input wire logic pix_override_in,
   input wire logic line_end_in,
   input wire logic screen_end_in
);
   logic [8:0] colour_q[$];
   logic ovr_q[$];
   int n_line;
   int n_screen;
   // the mixer never stalls, so a late pixel is caught as a count error
   always @(posedge clk_in) begin
      if (clr_in) begin
         colour_q.delete();
         ovr_q.delete();
         n_line = 0;
         n_screen = 0;
      end else begin
         // one window per stream: overlap and gap never arise here
         if (pix_valid_in === 1'b1) begin
            colour_q.push_back(pix_colour_in);
            ovr_q.push_back(pix_override_in);
         end
         if (line_end_in === 1'b1) n_line++;
         if (screen_end_in === 1'b1) n_screen++;
      end
   end
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import ogfx_pkg::*;
   logic core_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, req = 0, clr = 0;
   logic [3:0] adr = 4'h0, sel = 4'hF, feat = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, wb_q;
   logic ack, busy, pv, po, le, se;
   logic [1:0] slot = 2'h0;
   logic [2:0] bank = 3'h0;
   logic [7:0] code = 8'h00;
   logic [8:0] c0 = 9'h011, c1 = 9'h1C2, pc;
   logic rwe = 0;
   logic [19:0] rwa = 20'h0;
   logic [11:0] rwd = 12'h0;
   int failures = 0, n_checks = 0;
   int busy_n = 0;
   localparam logic [8:0] OVR = 9'h1A5;
   always #2.5 core_clk = ~core_clk;
   ogfx_effects dut (.core_clk_in(core_clk), .reset_n_in(reset_n), .wb_adr_in(adr),
      .wb_dat_in(wdat), .wb_we_in(we), .wb_sel_in(sel), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_dat_out(rdat), .wb_ack_out(ack), .cell_req_in(req), .cell_code_in(code),
      .bank_slot_in(slot), .bank_in(bank), .feature_select_bits_in(feat), .colour0_in(c0),
      .colour1_in(c1), .rom_we_in(rwe), .rom_waddr_in(rwa), .rom_wdata_in(rwd),
      .cell_busy_out(busy), .pix_valid_out(pv), .pix_colour_out(pc), .pix_override_out(po),
      .line_end_out(le), .screen_end_out(se));
   ogfx_mixer_model mixer (.clk_in(core_clk), .clr_in(clr), .pix_valid_in(pv),
      .pix_colour_in(pc), .pix_override_in(po), .line_end_in(le), .screen_end_in(se));
   task automatic close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (ack !== 1'b1 && k < 100);
      if (k == 100) failures++;
      wb_q = rdat;
      cyc <= 0;
      stb <= 0;
      we <= 0;
   endtask
   function automatic logic [11:0] row(int r);
      // a missing row beyond the glyph reads as blank
      if (r < 0 || r > 17) return 12'h000;
      return (12'h813 << (r % 12)) | (12'h813 >> (12 - r % 12));
   endfunction
   function automatic logic mask(int f, int r, int b);
      logic [11:0] c, u;
      c = row(r);
      u = row(r - 1);
      if (c[b]) return 0;
      if (f == 1) return b < 11 && u[b + 1];
      if (f == 2) begin
         for (int dr = -1; dr <= 1; dr++) begin
            u = row(r + dr);
            for (int db = -1; db <= 1; db++)
               if (b + db >= 0 && b + db <= 11 && u[b + db]) return 1;
         end
      end
      return 0;
   endfunction
   task automatic load(input logic [2:0] bk, input logic [7:0] c);
      for (int r = 0; r < 18; r++) begin
         @(posedge core_clk);
         rwe <= 1;
         rwa <= {1'b0, bk, c, 3'b000, 5'(r)};
         rwd <= row(r);
      end
      @(posedge core_clk);
      rwe <= 0;
   endtask
   task automatic render(input logic [3:0] f, input logic [1:0] s, input logic [2:0] bk,
                         input logic [7:0] c);
      int k;
      @(posedge core_clk);
      clr <= 1;
      feat <= f;
      slot <= s;
      bank <= bk;
      code <= c;
      @(posedge core_clk);
      clr <= 0;
      req <= 1;
      @(posedge core_clk);
      req <= 0;
      // busy_n counts the edges at which the cell is seen busy
      k = 0;
      busy_n = 0;
      do begin
         @(posedge core_clk);
         k++;
         if (busy === 1'b1) busy_n++;
      end while ((busy === 1'b1 || k < 3) && k < 5000);
      if (k == 5000) failures++;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic test_regs;
      wb(0, REG_CTRL, 0);
      check(wb_q, 0);
      wb(0, REG_OVR_COLOUR, 0);
      check(wb_q, 0);
      wb(0, REG_LINES, 0);
      check(wb_q, 0);
      wb(0, REG_STATUS, 0);
      check(wb_q, 8);
      wb(1, REG_OVR_COLOUR, 32'(OVR));
      wb(0, REG_OVR_COLOUR, 0);
      check(wb_q, 32'(OVR));
      wb(1, 4'h2, 32'hFFFFFFFF);
      wb(0, 4'h2, 0);
      check(wb_q, 0);
      wb(1, REG_LINES, 240);
      wb(1, REG_CTRL, 1);
   endtask
   task automatic test_effects;
      logic [3:0] fs[4] = '{4'h0, 4'h1, 4'h2, 4'h8};
      int r, b;
      logic m;
      logic [11:0] g;
      for (int j = 0; j < 4; j++) begin
         render(fs[j], 2'h1, 3'h3, 8'h40);
         check(mixer.colour_q.size(), 216);
         // 18 rows of 4 fetch and 12 pixel cycles, then one closing cycle
         check(busy_n, 289);
         for (int i = 0; i < mixer.colour_q.size() && i < 216; i++) begin
            r = i / 12;
            b = 11 - i % 12;
            g = row(r);
            // the perimeter of a bordered glyph lacks neighbours and is not judged
            if (fs[j] == 2 && (r == 0 || r == 17 || b == 0 || b == 11)) continue;
            m = mask(fs[j], r, b);
            check(mixer.ovr_q[i], m);
            check(mixer.colour_q[i], m ? OVR : (g[b] ? c1 : c0));
         end
      end
   endtask
   task automatic test_terms;
      render(4'h0, 2'h0, 3'h2, SCREEN_TERM_CODE);
      check(mixer.n_screen, 1);
      check(busy_n, 0);
      check(mixer.colour_q.size(), 0);
      render(4'h0, 2'h0, 3'h2, LINE_TERM_CODE);
      check(mixer.n_line, 1);
      for (int s = 1; s < 4; s++) begin
         render(4'h0, 2'(s), 3'h2, SCREEN_TERM_CODE);
         check(mixer.n_screen, 0);
         check(mixer.colour_q.size(), 216);
      end
   endtask
   task automatic test_repeat;
      wb(1, REG_LINES, 480);
      wb(0, REG_STATUS, 0);
      check(wb_q, 16);
      render(4'h0, 2'h1, 3'h3, 8'h40);
      check(mixer.colour_q.size() > 216, 1);
      check(mixer.colour_q.size() % 12, 0);
      // twice the scan lines: every glyph row is shown twice, fetched once
      check(mixer.colour_q.size(), 432);
      check(busy_n, 505);
      // leftmost pixel: lit in row 0 and its repeat, blank in row 1
      check(mixer.colour_q[12], c1);
      check(mixer.colour_q[24], c0);
      wb(1, REG_LINES, 240);
   endtask
   initial begin
      #250000;
      failures++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      reset_n <= 1;
      @(posedge core_clk);
      test_regs();
      load(3'h3, 8'h40);
      load(3'h2, 8'h00);
      test_effects();
      test_terms();
      test_repeat();
      close_out();
   end
endmodule
